// >>> can_txdto_regs.vh
// constants for the transmit dominant timeout block
// How it works
// (R1) driver disabled, bus released recessive when transmit line dominant over 1.2 ms.
// (R2) after trip, driver stays off until transmit line first returns high.
// (R3) controller holds dominant at most eleven bits; bit rate at least 9.2 kbps.
// (R4) recessive is logic high and also the idle state.
// (R5) dominant is logic low.
// (R6) received bus is wired-AND of all drivers; any dominant wins.
// (R7) test mode routes internal lines to pins; transceiver and controller sides separate.
// (R8) a single-ended clock derived from device clock can drive a general pin.
// (R9) device clock of 40 MHz recommended for 5 Mbps data phase.
// (R10) dominant counter runs while line low, clears when sampled high.
`ifndef CAN_TXDTO_REGS_VH
`define CAN_TXDTO_REGS_VH
`define CLK_FREQ_HZ        40000000
`define DTO_TIME_US        1200
`define DTO_CYCLES         ((`DTO_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define DTO_CNT_W          16
`define CLKOUT_DIV_DEF     4
`define LVL_RECESSIVE      1'b1
`define LVL_DOMINANT       1'b0
`endif

// >>> can_clk_divider.v
// clock output divider for the general-purpose pin
`timescale 1ns/10ps
module can_clk_divider #(
  parameter DIV_W = 8
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire             enable_i,
  input  wire [DIV_W-1:0] half_period_i,
  output reg              clk_div_o
);
  reg [DIV_W-1:0] cnt_r;

  // toggles every half_period cycles; half_period 0 treated as 1 [R8]
  always @(posedge clock_i) begin
    if (sys_rst_i || !enable_i) begin
      cnt_r     <= {DIV_W{1'b0}};
      clk_div_o <= 1'b0;
    end else if (cnt_r + {{(DIV_W-1){1'b0}}, 1'b1} >= half_period_i) begin
      cnt_r     <= {DIV_W{1'b0}};
      clk_div_o <= ~clk_div_o;
    end else begin
      cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // can_clk_divider

// >>> can_tx_dominant_timeout.v
// transmit dominant timeout, bus resolution, test routing and clock output
`timescale 1ns/10ps
`include "can_txdto_regs.vh"
module can_tx_dominant_timeout #(
  parameter DTO_CYCLES = `DTO_CYCLES,
  parameter DIV_W      = 8
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire             ctrl_txd_i,
  input  wire             bus_rx_i,
  input  wire             test_mode_i,
  input  wire             test_sel_phy_i,
  input  wire             test_pin_txd_i,
  input  wire             clkout_en_i,
  input  wire [DIV_W-1:0] clkout_half_i,
  output reg              drv_txd_o,
  output reg              drv_en_o,
  output reg              ctrl_rxd_o,
  output reg              test_pin_rxd_o,
  output reg              dto_tripped_o,
  output wire             clock_output_pin_o
);
  reg                  txd_s1_r;
  reg                  txd_s2_r;
  reg                  rx_s1_r;
  reg                  rx_s2_r;
  reg                  tpin_s1_r;
  reg                  tpin_s2_r;
  reg [`DTO_CNT_W-1:0] dom_cnt_r;
  reg [`DTO_CNT_W-1:0] dom_cnt_nxt;
  reg                  trip_r;
  reg                  trip_nxt;
  reg                  tx_line;
  reg                  own_level;
  reg                  rx_wired;
  reg                  drv_txd_nxt;
  reg                  drv_en_nxt;
  reg                  test_rxd_nxt;

  localparam [`DTO_CNT_W-1:0] DTO_LIMIT = DTO_CYCLES[`DTO_CNT_W-1:0];
  localparam [`DTO_CNT_W-1:0] CNT_ZERO  = {`DTO_CNT_W{1'b0}};
  localparam [`DTO_CNT_W-1:0] CNT_ONE   = {{(`DTO_CNT_W-1){1'b0}}, 1'b1};

  // wired-and of two bus levels
  function wand2;
    input a;
    input b;
    begin
      wand2 = a & b;
    end
  endfunction

  // true when a level is recessive
  function is_recessive;
    input lvl;
    begin
      is_recessive = (lvl == `LVL_RECESSIVE);
    end
  endfunction

  // two-flop synchroniser, controller transmit line
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      txd_s1_r <= `LVL_RECESSIVE;
      txd_s2_r <= `LVL_RECESSIVE;
    end else begin
      txd_s1_r <= ctrl_txd_i;
      txd_s2_r <= txd_s1_r;
    end
  end

  // two-flop synchroniser, bus receive line
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_s1_r <= `LVL_RECESSIVE;
      rx_s2_r <= `LVL_RECESSIVE;
    end else begin
      rx_s1_r <= bus_rx_i;
      rx_s2_r <= rx_s1_r;
    end
  end

  // two-flop synchroniser, test pin transmit line
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      tpin_s1_r <= `LVL_RECESSIVE;
      tpin_s2_r <= `LVL_RECESSIVE;
    end else begin
      tpin_s1_r <= test_pin_txd_i;
      tpin_s2_r <= tpin_s1_r;
    end
  end

  // in test mode with phy side selected, pin drives the transmit line [R7]
  always @* begin
    tx_line = txd_s2_r;
    if (test_mode_i && test_sel_phy_i) begin
      tx_line = tpin_s2_r;
    end
  end

  // level this node puts on the bus
  always @* begin
    own_level = `LVL_RECESSIVE;
    if (drv_en_o) begin
      own_level = drv_txd_o;
    end
  end

  // bus reads dominant if bus or own driver is dominant [R6]
  always @* begin
    rx_wired = wand2(rx_s2_r, own_level);
  end

  // dominant duration counter next value
  always @* begin
    dom_cnt_nxt = dom_cnt_r;
    if (is_recessive(tx_line)) begin
      dom_cnt_nxt = CNT_ZERO; // [R10] [R4]
    end else if (dom_cnt_r < DTO_LIMIT) begin
      dom_cnt_nxt = dom_cnt_r + CNT_ONE; // [R10] [R5]
    end
  end

  // trip latch next value; only a recessive line clears it
  always @* begin
    trip_nxt = trip_r;
    if (is_recessive(tx_line)) begin
      trip_nxt = 1'b0; // [R2]
    end else if (dom_cnt_r >= DTO_LIMIT) begin
      trip_nxt = 1'b1; // [R1] [R3]
    end
  end

  // dominant duration counter
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dom_cnt_r <= CNT_ZERO;
    end else begin
      dom_cnt_r <= dom_cnt_nxt;
    end
  end

  // trip latch
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      trip_r <= 1'b0;
    end else begin
      trip_r <= trip_nxt;
    end
  end

  // driver next values; tripped driver releases to recessive
  always @* begin
    drv_en_nxt  = 1'b1;
    drv_txd_nxt = tx_line;
    if (trip_r) begin
      drv_en_nxt  = 1'b0;           // [R1] [R2]
      drv_txd_nxt = `LVL_RECESSIVE; // [R1] [R2]
    end
  end

  // test pin receive selection [R7]
  always @* begin
    test_rxd_nxt = `LVL_RECESSIVE;
    if (test_mode_i) begin
      if (test_sel_phy_i) begin
        test_rxd_nxt = rx_wired;
      end else begin
        test_rxd_nxt = txd_s2_r;
      end
    end
  end

  // driver enable
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      drv_en_o <= 1'b0;
    end else begin
      drv_en_o <= drv_en_nxt;
    end
  end

  // driver data
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      drv_txd_o <= `LVL_RECESSIVE;
    end else begin
      drv_txd_o <= drv_txd_nxt;
    end
  end

  // resolved bus to controller [R6]
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_rxd_o <= `LVL_RECESSIVE;
    end else begin
      ctrl_rxd_o <= rx_wired;
    end
  end

  // test pin receive output [R7]
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      test_pin_rxd_o <= `LVL_RECESSIVE;
    end else begin
      test_pin_rxd_o <= test_rxd_nxt;
    end
  end

  // timeout status
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dto_tripped_o <= 1'b0;
    end else begin
      dto_tripped_o <= trip_r;
    end
  end

  // clock output derived from device clock [R8] [R9]
  can_clk_divider #(
    .DIV_W (DIV_W)
  ) u_clkdiv (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .enable_i      (clkout_en_i),
    .half_period_i (clkout_half_i),
    .clk_div_o     (clock_output_pin_o)
  );
endmodule // can_tx_dominant_timeout

// >>> txdto_sva.sv
// dominant timeout checker
`timescale 1ns/10ps
module txdto_sva #(parameter DTO_CYCLES = 20) (
  input wire logic clock_i, sys_rst_i, ctrl_txd_i, bus_rx_i, test_mode_i, test_sel_phy_i,
  input wire logic clkout_en_i, drv_txd_o, drv_en_o, ctrl_rxd_o, test_pin_rxd_o,
  input wire logic dto_tripped_o, clock_output_pin_o);
  int cnt;
  always @(posedge clock_i) cnt <= (sys_rst_i || ctrl_txd_i) ? 0 : cnt + 1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_late_trip: assert property (cnt == DTO_CYCLES + 8 |-> !drv_en_o && drv_txd_o)
    else $error("late trip");
  chk_early_trip: assert property ($rose(dto_tripped_o) |-> cnt >= DTO_CYCLES)
    else $error("early trip");
  chk_trip_hold: assert property ((dto_tripped_o && !ctrl_txd_i) [*4] |=> !drv_en_o)
    else $error("rearmed");
  chk_rst_idle: assert property (disable iff (1'b0) sys_rst_i |=> drv_txd_o && !drv_en_o)
    else $error("not idle");
  chk_drv_dom: assert property ((!dto_tripped_o && !ctrl_txd_i) [*4] |-> !drv_txd_o)
    else $error("no dominant");
  chk_rx_and: assert property (!bus_rx_i [*4] |-> !ctrl_rxd_o) else $error("rx");
  chk_test_ctrl: assert property (
    (test_mode_i && !test_sel_phy_i && !ctrl_txd_i) [*4] |-> !test_pin_rxd_o) else $error("pin");
  chk_clk_off: assert property ((!clkout_en_i) [*3] |-> !clock_output_pin_o)
    else $error("clock out");
endmodule // txdto_sva
bind can_tx_dominant_timeout txdto_sva #(.DTO_CYCLES(DTO_CYCLES)) chk_i (.*);

// >>> ctrl_model.sv
// controller model driving the transmit line
`timescale 1ns/10ps
module ctrl_model (input wire logic clock_i, output logic txd_o = 1'b1);
  task automatic send(int len); // over eleven bits only when told
    @(negedge clock_i) txd_o = 1'b0;
    repeat (len) @(negedge clock_i);
    txd_o = 1'b1;
  endtask
endmodule // ctrl_model

// >>> tb.sv
// testbench for the dominant timeout block
`timescale 1ns/10ps
module tb;
  logic clock_i = 0, sys_rst_i = 1, bus_rx_i = 1, test_mode_i = 0, test_sel_phy_i = 0, c;
  logic test_pin_txd_i = 1, clkout_en_i = 0;
  logic [7:0] clkout_half_i = 8'h01;
  wire ctrl_txd_i, drv_txd_o, drv_en_o, ctrl_rxd_o, test_pin_rxd_o, dto_tripped_o;
  wire clock_output_pin_o;
  int fail_count = 0, cmp_count = 0;
  can_tx_dominant_timeout #(.DTO_CYCLES(20)) uut (.*);
  ctrl_model m (.clock_i, .txd_o(ctrl_txd_i));
  initial forever #12.5 clock_i = ~clock_i;
  task cyc(int n); repeat (n) @(negedge clock_i); endtask
  task chk(string n, logic e, logic s);
    cmp_count++;
    if (s !== e) begin fail_count++; $display("mismatch %s exp %b got %b", n, e, s); end
  endtask
  task print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_frames; // one recessive cycle between frames
    m.send(15);
    m.send(15);
    chk("trip", 0, dto_tripped_o);
  endtask
  task t_trip;
    fork m.send(40); join_none
    cyc(34);
    chk("en", 0, drv_en_o);
    chk("txd", 1, drv_txd_o);
    chk("trip", 1, dto_tripped_o);
    repeat (20) if (drv_en_o !== 1) cyc(1);
    chk("en", 1, drv_en_o);
    if (drv_en_o !== 1) print_verdict;
  endtask
  task t_misc;
    bus_rx_i = 0; cyc(4); chk("rxd", 0, ctrl_rxd_o);
    bus_rx_i = 1; test_mode_i = 1;
    fork m.send(6); begin cyc(5); chk("tpin", 0, test_pin_rxd_o); end join
    test_sel_phy_i = 1; test_pin_txd_i = 0; cyc(5); chk("ptxd", 0, drv_txd_o);
    chk("prxd", 0, test_pin_rxd_o);
    test_mode_i = 0; test_pin_txd_i = 1; clkout_en_i = 1; cyc(4); c = clock_output_pin_o;
    cyc(1); chk("clk", !c, clock_output_pin_o);
  endtask
  initial begin
    cyc(5); chk("en", 0, drv_en_o);
    sys_rst_i = 0; cyc(3); t_frames; t_trip; t_misc; print_verdict;
  end
endmodule // tb
